// file: rtl/bsd_consts.svh
// boundary scan constants: register sizes, cell positions, opcodes
// assumes inclusion by the package, the main design file and the assertion file only
`ifndef BSD_CONSTS_SVH
`define BSD_CONSTS_SVH

// register lengths
`define BSD_IR_W 8
`define BSD_BSR_W 36
`define BSD_BCR_W 11
`define BSD_PIN_W 8

// cell positions in the boundary chain
`define BSD_CELL_B_EN 35
`define BSD_CELL_A_EN 34
`define BSD_CELL_DIR 33
`define BSD_CELL_OE 32
`define BSD_B_IN_LSB 24
`define BSD_B_OUT_LSB 16
`define BSD_A_IN_LSB 8
`define BSD_A_OUT_LSB 0

// run-test control fields and reset value
`define BSD_BCR_MASK_LSB 3
`define BSD_BCR_RST 11'h002
`define BSD_RUN_OP_TOPSIP 2'h0

// instruction reset and capture values
`define BSD_IR_RST 8'hff
`define BSD_IR_CAPTURE 8'h81

// instruction opcodes
`define BSD_OP_EXTEST_A 8'h00
`define BSD_OP_EXTEST_B 8'h03
`define BSD_OP_SAMPLE 8'h82
`define BSD_OP_HIGHZ 8'h06
`define BSD_OP_CLAMP 8'h87
`define BSD_OP_RUN_TEST 8'h09
`define BSD_OP_READ_NORMAL 8'h0a
`define BSD_OP_READ_TEST 8'h8b
`define BSD_OP_SELF_CHECK 8'h0c
`define BSD_OP_TOGGLE 8'h8d
`define BSD_OP_CTRL_NORMAL 8'h8e
`define BSD_OP_CTRL_TEST 8'h0f

`endif

// file: rtl/bsd_pkg.sv
// types shared by the boundary scan block and its tap controller
// assumes bsd_consts.svh is on the include path
`include "bsd_consts.svh"

package bsd_pkg;

  // tap controller states
  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr,
    st_pause_dr, st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir,
    st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } bsd_tap_state_type;

  // data register in the scan path
  typedef enum logic [1:0] {
    dr_bypass, dr_chain, dr_control
  } bsd_dr_sel_type;

  // what the chain loads at capture
  typedef enum logic [1:0] {
    cap_pins, cap_hold, cap_invert
  } bsd_capture_type;

  // activity in run-test/idle
  typedef enum logic [1:0] {
    rti_none, rti_run, rti_toggle
  } bsd_rti_type;

  // decoded instruction
  typedef struct packed {
    bsd_dr_sel_type dr_sel;
    logic test_mode;
    logic highz;
    bsd_capture_type capture;
    bsd_rti_type rti;
  } bsd_decode_type;

  // mode and shadow chain handed to the pin side
  typedef struct packed {
    logic test_mode;
    logic highz;
    logic [`BSD_BSR_W-1:0] chain;
  } bsd_drive_word_type;

  // transceiver pin drive, enables low while driving
  typedef struct packed {
    logic [`BSD_PIN_W-1:0] a_out;
    logic [`BSD_PIN_W-1:0] a_oe_n;
    logic [`BSD_PIN_W-1:0] b_out;
    logic [`BSD_PIN_W-1:0] b_oe_n;
  } bsd_pin_drive_type;

endpackage : bsd_pkg

// file: rtl/bsd_tap_ctrl.sv
// four-wire tap state machine, stepped on the rising test clock
// assumes tms is launched on the falling test clock by the controller
`timescale 1ns/1ps
`default_nettype none

module bsd_tap_ctrl (
  input wire logic tck,
  input wire logic rst,
  input wire logic tms,
  output var bsd_pkg::bsd_tap_state_type state
);

  typedef struct packed {
    bsd_pkg::bsd_tap_state_type state;
  } bsd_tap_reg_type;

  bsd_tap_reg_type r_reg;
  bsd_tap_reg_type r_next;

  // standard tap walk; rst forces test-logic-reset
  always_comb begin
    r_next = r_reg;
    unique case (r_reg.state)
      bsd_pkg::st_reset:
        r_next.state = tms ? bsd_pkg::st_reset : bsd_pkg::st_idle;
      bsd_pkg::st_idle:
        r_next.state = tms ? bsd_pkg::st_sel_dr : bsd_pkg::st_idle;
      bsd_pkg::st_sel_dr:
        r_next.state = tms ? bsd_pkg::st_sel_ir : bsd_pkg::st_cap_dr;
      bsd_pkg::st_cap_dr:
        r_next.state = tms ? bsd_pkg::st_exit1_dr : bsd_pkg::st_shift_dr;
      bsd_pkg::st_shift_dr:
        r_next.state = tms ? bsd_pkg::st_exit1_dr : bsd_pkg::st_shift_dr;
      bsd_pkg::st_exit1_dr:
        r_next.state = tms ? bsd_pkg::st_upd_dr : bsd_pkg::st_pause_dr;
      bsd_pkg::st_pause_dr:
        r_next.state = tms ? bsd_pkg::st_exit2_dr : bsd_pkg::st_pause_dr;
      bsd_pkg::st_exit2_dr:
        r_next.state = tms ? bsd_pkg::st_upd_dr : bsd_pkg::st_shift_dr;
      bsd_pkg::st_upd_dr:
        r_next.state = tms ? bsd_pkg::st_sel_dr : bsd_pkg::st_idle;
      bsd_pkg::st_sel_ir:
        r_next.state = tms ? bsd_pkg::st_reset : bsd_pkg::st_cap_ir;
      bsd_pkg::st_cap_ir:
        r_next.state = tms ? bsd_pkg::st_exit1_ir : bsd_pkg::st_shift_ir;
      bsd_pkg::st_shift_ir:
        r_next.state = tms ? bsd_pkg::st_exit1_ir : bsd_pkg::st_shift_ir;
      bsd_pkg::st_exit1_ir:
        r_next.state = tms ? bsd_pkg::st_upd_ir : bsd_pkg::st_pause_ir;
      bsd_pkg::st_pause_ir:
        r_next.state = tms ? bsd_pkg::st_exit2_ir : bsd_pkg::st_pause_ir;
      bsd_pkg::st_exit2_ir:
        r_next.state = tms ? bsd_pkg::st_upd_ir : bsd_pkg::st_shift_ir;
      bsd_pkg::st_upd_ir:
        r_next.state = tms ? bsd_pkg::st_sel_dr : bsd_pkg::st_idle;
    endcase
    if (rst) begin
      r_next.state = bsd_pkg::st_reset;
    end
  end

  always_ff @(posedge tck) begin
    r_reg <= r_next;
  end

  assign state = r_reg.state;

endmodule : bsd_tap_ctrl

`default_nettype wire

// file: rtl/bsd_boundary_regs.sv
// boundary scan data registers, instruction decode and transceiver pins
// assumes tck from the scan controller, pins asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "bsd_consts.svh"

module bsd_boundary_regs (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [`BSD_PIN_W-1:0] a_in,
  input wire logic [`BSD_PIN_W-1:0] b_in,
  input wire logic oe_n,
  input wire logic dir,
  output var bsd_pkg::bsd_pin_drive_type pins
);

  // pin-side state on clk_sys
  typedef struct packed {
    logic [`BSD_PIN_W-1:0] a_s1;
    logic [`BSD_PIN_W-1:0] a_s2;
    logic [`BSD_PIN_W-1:0] b_s1;
    logic [`BSD_PIN_W-1:0] b_s2;
    logic oe_n_s1;
    logic oe_n_s2;
    logic dir_s1;
    logic dir_s2;
    logic cap_ack_s1;
    logic cap_ack_s2;
    logic cap_req;
    logic [`BSD_BSR_W-1:0] cap_word;
    logic drv_req_s1;
    logic drv_req_s2;
    logic drv_ack;
    bsd_pkg::bsd_drive_word_type drv_word;
    bsd_pkg::bsd_pin_drive_type pins;
  } bsd_sys_state_type;

  // scan-side state on the rising test clock
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic cap_req_s1;
    logic cap_req_s2;
    logic cap_ack;
    logic [`BSD_BSR_W-1:0] cap_word;
    logic drv_ack_s1;
    logic drv_ack_s2;
    logic drv_req;
    bsd_pkg::bsd_drive_word_type drv_word;
    logic [`BSD_IR_W-1:0] ir_sr;
    logic [`BSD_BSR_W-1:0] bsr_sr;
    logic [`BSD_BCR_W-1:0] bcr_sr;
    logic byp;
  } bsd_tck_state_type;

  // shadow latches and tdo on the falling test clock
  typedef struct packed {
    logic [`BSD_IR_W-1:0] ir_act;
    logic [`BSD_BSR_W-1:0] bsr_sh;
    logic [`BSD_BCR_W-1:0] bcr_sh;
    logic tdo;
    logic tdo_oe_n;
  } bsd_neg_state_type;

  bsd_sys_state_type sys_reg;
  bsd_sys_state_type sys_next;
  bsd_tck_state_type tck_reg;
  bsd_tck_state_type tck_next;
  bsd_neg_state_type neg_reg;
  bsd_neg_state_type neg_next;

  bsd_pkg::bsd_tap_state_type tap;
  bsd_pkg::bsd_decode_type dec;
  logic scan_rst;
  logic run_go;
  logic run_sample;
  logic a_to_b;
  logic a_en_dec;
  logic b_en_dec;
  logic [`BSD_PIN_W-1:0] core_a;
  logic [`BSD_PIN_W-1:0] core_b;
  logic [`BSD_BSR_W-1:0] shadow;

  // instruction table; parity is the controller's job, so odd codes
  // simply miss every entry and fall to bypass
  function automatic bsd_pkg::bsd_decode_type bsd_decode(
    input logic [`BSD_IR_W-1:0] op
  );
    bsd_pkg::bsd_decode_type d;
    d.dr_sel = bsd_pkg::dr_bypass;
    d.test_mode = 1'b0;
    d.highz = 1'b0;
    d.capture = bsd_pkg::cap_pins;
    d.rti = bsd_pkg::rti_none;
    case (op)
      `BSD_OP_EXTEST_A, `BSD_OP_EXTEST_B: begin
        d.dr_sel = bsd_pkg::dr_chain;
        d.test_mode = 1'b1;
      end
      `BSD_OP_SAMPLE: begin
        d.dr_sel = bsd_pkg::dr_chain;
      end
      `BSD_OP_HIGHZ: begin
        d.highz = 1'b1;
      end
      `BSD_OP_CLAMP: begin
        d.test_mode = 1'b1;
      end
      `BSD_OP_RUN_TEST: begin
        d.test_mode = 1'b1;
        d.rti = bsd_pkg::rti_run;
      end
      `BSD_OP_READ_NORMAL: begin
        d.dr_sel = bsd_pkg::dr_chain;
        d.capture = bsd_pkg::cap_hold;
      end
      `BSD_OP_READ_TEST: begin
        d.dr_sel = bsd_pkg::dr_chain;
        d.capture = bsd_pkg::cap_hold;
        d.test_mode = 1'b1;
      end
      `BSD_OP_SELF_CHECK: begin
        d.dr_sel = bsd_pkg::dr_chain;
        d.capture = bsd_pkg::cap_invert;
      end
      `BSD_OP_TOGGLE: begin
        d.test_mode = 1'b1;
        d.rti = bsd_pkg::rti_toggle;
      end
      `BSD_OP_CTRL_NORMAL: begin
        d.dr_sel = bsd_pkg::dr_control;
      end
      `BSD_OP_CTRL_TEST: begin
        d.dr_sel = bsd_pkg::dr_control;
        d.test_mode = 1'b1;
      end
      default: begin
        d.dr_sel = bsd_pkg::dr_bypass;
      end
    endcase
    return d;
  endfunction : bsd_decode

  bsd_tap_ctrl u_tap (
    .tck(tck),
    .rst(tck_reg.rst_s2),
    .tms(tms),
    .state(tap)
  );

  // decode follows the falling-edge instruction shadow
  assign dec = bsd_decode(neg_reg.ir_act);
  assign scan_rst = tck_reg.rst_s2 || (tap == bsd_pkg::st_reset);

  // run-test only acts with exactly one side enabled
  assign a_to_b = neg_reg.bsr_sh[`BSD_CELL_B_EN];
  assign run_sample = (dec.rti == bsd_pkg::rti_run) &&
    (neg_reg.bcr_sh[1:0] == `BSD_RUN_OP_TOPSIP);
  assign run_go = (tap == bsd_pkg::st_idle) &&
    ((dec.rti == bsd_pkg::rti_toggle) || run_sample) &&
    (neg_reg.bsr_sh[`BSD_CELL_B_EN] != neg_reg.bsr_sh[`BSD_CELL_A_EN]);

  // rising test clock: crossings, capture and shift
  always_comb begin
    tck_next = tck_reg;
    tck_next.rst_s1 = sys_rst;
    tck_next.rst_s2 = tck_reg.rst_s1;
    tck_next.cap_req_s1 = sys_reg.cap_req;
    tck_next.cap_req_s2 = tck_reg.cap_req_s1;
    tck_next.drv_ack_s1 = sys_reg.drv_ack;
    tck_next.drv_ack_s2 = tck_reg.drv_ack_s1;
    // pin snapshot is stable while the request is outstanding
    if (tck_reg.cap_req_s2 != tck_reg.cap_ack) begin
      tck_next.cap_word = sys_reg.cap_word;
      tck_next.cap_ack = ~tck_reg.cap_ack;
    end
    // offer mode and shadow to the pin side once the last one landed
    if (tck_reg.drv_ack_s2 == tck_reg.drv_req) begin
      tck_next.drv_word.test_mode = dec.test_mode;
      tck_next.drv_word.highz = dec.highz;
      tck_next.drv_word.chain = neg_reg.bsr_sh;
      tck_next.drv_req = ~tck_reg.drv_req;
    end
    case (tap)
      bsd_pkg::st_cap_dr: begin
        case (dec.dr_sel)
          bsd_pkg::dr_bypass: tck_next.byp = 1'b0;
          bsd_pkg::dr_chain: begin
            if (dec.capture == bsd_pkg::cap_pins) begin
              tck_next.bsr_sr = tck_reg.cap_word;
            end else if (dec.capture == bsd_pkg::cap_invert) begin
              tck_next.bsr_sr = ~neg_reg.bsr_sh;
            end
          end
          default: begin
            tck_next.bcr_sr = tck_reg.bcr_sr;
          end
        endcase
      end
      bsd_pkg::st_shift_dr: begin
        case (dec.dr_sel)
          bsd_pkg::dr_bypass: tck_next.byp = tdi;
          bsd_pkg::dr_chain: begin
            tck_next.bsr_sr = {tdi, tck_reg.bsr_sr[`BSD_BSR_W-1:1]};
          end
          default: begin
            tck_next.bcr_sr = {tdi, tck_reg.bcr_sr[`BSD_BCR_W-1:1]};
          end
        endcase
      end
      bsd_pkg::st_cap_ir: tck_next.ir_sr = `BSD_IR_CAPTURE;
      bsd_pkg::st_shift_ir: begin
        tck_next.ir_sr = {tdi, tck_reg.ir_sr[`BSD_IR_W-1:1]};
      end
      bsd_pkg::st_idle: begin
        // toggle selected outputs, sample selected inputs under topsip
        if (run_go && a_to_b) begin
          tck_next.bsr_sr[`BSD_B_OUT_LSB +: `BSD_PIN_W] =
            ~tck_reg.bsr_sr[`BSD_B_OUT_LSB +: `BSD_PIN_W];
          if (run_sample) begin
            tck_next.bsr_sr[`BSD_A_IN_LSB +: `BSD_PIN_W] =
              tck_reg.cap_word[`BSD_A_IN_LSB +: `BSD_PIN_W];
          end
        end else if (run_go) begin
          tck_next.bsr_sr[`BSD_A_OUT_LSB +: `BSD_PIN_W] =
            ~tck_reg.bsr_sr[`BSD_A_OUT_LSB +: `BSD_PIN_W];
          if (run_sample) begin
            tck_next.bsr_sr[`BSD_B_IN_LSB +: `BSD_PIN_W] =
              tck_reg.cap_word[`BSD_B_IN_LSB +: `BSD_PIN_W];
          end
        end
      end
      default: begin
        tck_next.byp = tck_reg.byp;
      end
    endcase
    // handshake toggles follow only the system reset, so the two
    // sides never disagree after a tap-only reset
    if (tck_reg.rst_s2) begin
      tck_next.cap_ack = 1'b0;
      tck_next.drv_req = 1'b0;
    end
    if (scan_rst) begin
      tck_next.ir_sr = `BSD_IR_RST;
      tck_next.bsr_sr = '0;
      tck_next.bcr_sr = `BSD_BCR_RST;
      tck_next.byp = 1'b0;
    end
  end

  always_ff @(posedge tck) begin
    tck_reg <= tck_next;
  end

  // falling test clock: shadow updates and tdo
  always_comb begin
    neg_next = neg_reg;
    case (tap)
      bsd_pkg::st_upd_ir: neg_next.ir_act = tck_reg.ir_sr;
      bsd_pkg::st_upd_dr: begin
        if (dec.dr_sel == bsd_pkg::dr_chain) begin
          neg_next.bsr_sh = tck_reg.bsr_sr;
        end else if (dec.dr_sel == bsd_pkg::dr_control) begin
          neg_next.bcr_sh = tck_reg.bcr_sr;
        end
      end
      bsd_pkg::st_idle: begin
        if (run_go) begin
          neg_next.bsr_sh = tck_reg.bsr_sr;
        end
      end
      default: begin
        neg_next.ir_act = neg_reg.ir_act;
      end
    endcase
    // tdo floats outside shift states, lsb of selected path first
    neg_next.tdo_oe_n = 1'b1;
    if (tap == bsd_pkg::st_shift_dr) begin
      neg_next.tdo_oe_n = 1'b0;
      case (dec.dr_sel)
        bsd_pkg::dr_bypass: neg_next.tdo = tck_reg.byp;
        bsd_pkg::dr_chain: neg_next.tdo = tck_reg.bsr_sr[0];
        default: neg_next.tdo = tck_reg.bcr_sr[0];
      endcase
    end else if (tap == bsd_pkg::st_shift_ir) begin
      neg_next.tdo_oe_n = 1'b0;
      neg_next.tdo = tck_reg.ir_sr[0];
    end
    if (scan_rst) begin
      neg_next.ir_act = `BSD_IR_RST;
      neg_next.bsr_sh = '0;
      neg_next.bcr_sh = `BSD_BCR_RST;
      neg_next.tdo = 1'b0;
      neg_next.tdo_oe_n = 1'b1;
    end
  end

  always_ff @(negedge tck) begin
    neg_reg <= neg_next;
  end

  assign tdo = neg_reg.tdo;
  assign tdo_oe_n = neg_reg.tdo_oe_n;

  // core logic: in test mode it runs on the input cells
  assign shadow = sys_reg.drv_word.chain;
  assign core_a = sys_reg.drv_word.test_mode ?
    shadow[`BSD_B_IN_LSB +: `BSD_PIN_W] : sys_reg.b_s2;
  assign core_b = sys_reg.drv_word.test_mode ?
    shadow[`BSD_A_IN_LSB +: `BSD_PIN_W] : sys_reg.a_s2;
  // decoded port enables, active high in the cells
  assign a_en_dec = ~sys_reg.oe_n_s2 & ~sys_reg.dir_s2;
  assign b_en_dec = ~sys_reg.oe_n_s2 & sys_reg.dir_s2;

  // pin side: synchronisers, handshakes and pin drive
  always_comb begin
    sys_next = sys_reg;
    sys_next.a_s1 = a_in;
    sys_next.a_s2 = sys_reg.a_s1;
    sys_next.b_s1 = b_in;
    sys_next.b_s2 = sys_reg.b_s1;
    sys_next.oe_n_s1 = oe_n;
    sys_next.oe_n_s2 = sys_reg.oe_n_s1;
    sys_next.dir_s1 = dir;
    sys_next.dir_s2 = sys_reg.dir_s1;
    sys_next.cap_ack_s1 = tck_reg.cap_ack;
    sys_next.cap_ack_s2 = sys_reg.cap_ack_s1;
    sys_next.drv_req_s1 = tck_reg.drv_req;
    sys_next.drv_req_s2 = sys_reg.drv_req_s1;
    // take a new mode and shadow word
    if (sys_reg.drv_req_s2 != sys_reg.drv_ack) begin
      sys_next.drv_word = tck_reg.drv_word;
      sys_next.drv_ack = ~sys_reg.drv_ack;
    end
    // offer a fresh pin snapshot in chain order
    if (sys_reg.cap_ack_s2 == sys_reg.cap_req) begin
      sys_next.cap_word = {b_en_dec, a_en_dec, sys_reg.dir_s2,
        sys_reg.oe_n_s2, sys_reg.b_s2, core_b, sys_reg.a_s2,
        core_a};
      sys_next.cap_req = ~sys_reg.cap_req;
    end
    // normal transceiver path
    sys_next.pins.a_out = core_a;
    sys_next.pins.b_out = core_b;
    sys_next.pins.a_oe_n = {`BSD_PIN_W{~a_en_dec}};
    sys_next.pins.b_oe_n = {`BSD_PIN_W{~b_en_dec}};
    if (sys_reg.drv_word.highz) begin
      sys_next.pins.a_oe_n = '1;
      sys_next.pins.b_oe_n = '1;
    end else if (sys_reg.drv_word.test_mode) begin
      sys_next.pins.a_out = shadow[`BSD_A_OUT_LSB +: `BSD_PIN_W];
      sys_next.pins.b_out = shadow[`BSD_B_OUT_LSB +: `BSD_PIN_W];
      sys_next.pins.a_oe_n =
        {`BSD_PIN_W{~shadow[`BSD_CELL_A_EN]}};
      sys_next.pins.b_oe_n =
        {`BSD_PIN_W{~shadow[`BSD_CELL_B_EN]}};
    end
  end

  // pins float and the block sits in normal mode out of reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sys_reg <= '0;
      sys_reg.oe_n_s1 <= 1'b1;
      sys_reg.oe_n_s2 <= 1'b1;
      sys_reg.pins.a_oe_n <= '1;
      sys_reg.pins.b_oe_n <= '1;
    end else begin
      sys_reg <= sys_next;
    end
  end

  assign pins = sys_reg.pins;

endmodule : bsd_boundary_regs

`default_nettype wire

// file: tb/bsd_boundary_regs_sva.sv
// assertions on the scan port and the transceiver pin drive
// assumes binding onto bsd_boundary_regs, tms launched on falling tck
`timescale 1ns/1ps
`default_nettype none
`include "bsd_consts.svh"

module bsd_boundary_regs_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [`BSD_PIN_W-1:0] a_in,
  input wire logic [`BSD_PIN_W-1:0] b_in,
  input wire logic oe_n,
  input wire logic dir,
  input wire bsd_pkg::bsd_pin_drive_type pins
);
  // tms seen at a falling edge is the one the last rising edge used
  sequence sq_out_on;
    tdo_oe_n ##1 !tdo_oe_n;
  endsequence
  sequence sq_out_off;
    !tdo_oe_n ##1 tdo_oe_n;
  endsequence
  sequence sq_stay;
    !tdo_oe_n ##1 !tms;
  endsequence

  AST_SHIFT_ON: assert property (
    @(negedge tck) disable iff (sys_rst) sq_out_on |-> !tms)
    else $error("tdo enabled without shift entry");
  AST_SHIFT_OFF: assert property (
    @(negedge tck) disable iff (sys_rst) sq_out_off |-> tms)
    else $error("tdo released without shift exit");
  AST_SHIFT_STAY: assert property (
    @(negedge tck) disable iff (sys_rst) sq_stay |-> !tdo_oe_n)
    else $error("tdo released inside shift");
  // tdo and its enable move only right after the falling test clock
  AST_TDO_EDGE: assert property (
    @(posedge clk_sys) disable iff (sys_rst) $changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  AST_TDOEN_EDGE: assert property (
    @(posedge clk_sys) disable iff (sys_rst) $changed(tdo_oe_n) |-> !tck)
    else $error("tdo enable moved while tck high");
  // one enable cell per side, so a side drives all pins or none
  AST_A_UNIFORM: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pins.a_oe_n == 8'h00 || pins.a_oe_n == 8'hff)
    else $error("a side enables split");
  AST_B_UNIFORM: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pins.b_oe_n == 8'h00 || pins.b_oe_n == 8'hff)
    else $error("b side enables split");
  AST_RESET_PINS: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $fell(sys_rst) |-> pins == 32'h00ff00ff)
    else $error("pins driven out of reset");
endmodule : bsd_boundary_regs_sva

bind bsd_boundary_regs bsd_boundary_regs_sva chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe_n(tdo_oe_n), .a_in(a_in), .b_in(b_in), .oe_n(oe_n),
  .dir(dir), .pins(pins));
`default_nettype wire

// file: tb/bsd_scan_host.sv
// scan controller model driving the four-wire test port
// assumes the device samples tms and tdi on the rising test clock
`timescale 1ns/1ps
`default_nettype none

module bsd_scan_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // free running, the device needs tck edges during its reset
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    forever #32 tck = ~tck;
  end

  // one tap step; tdi keeps moving so a stale bit is never read
  task automatic step(input logic t);
    @(negedge tck);
    tms = t;
    tdi = ~tdi;
  endtask : step

  // five high steps reach test-logic-reset, then park in idle
  task automatic tap_reset();
    repeat (5) step(1'b1);
    step(1'b0);
  endtask : tap_reset

  // scan from idle back to idle, lsb first in and out
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
    output logic [39:0] dout);
    logic [39:0] d;
    d = din;
    dout = 40'h0;
    if (ir) begin
      d[7] = ^din[6:0];
    end
    step(1'b1);
    if (ir) begin
      step(1'b1);
    end
    step(1'b0);
    step(1'b0);
    for (int i = 0; i < n; i++) begin
      @(negedge tck);
      tms = (i == n - 1);
      tdi = d[i];
      @(posedge tck);
      dout[i] = tdo;
    end
    step(1'b1);
    step(1'b0);
  endtask : scan
endmodule : bsd_scan_host
`default_nettype wire

// file: tb/bsd_boundary_regs_tb.sv
// self-checking bench: scan host, bus wire resolution, behavioural model
// assumes the design, its package and the scan host model are compiled
`timescale 1ns/1ps
`default_nettype none

module bsd_boundary_regs_tb;
  logic clk_sys, sys_rst, tck, tms, tdi, tdo, tdo_oe_n, oe_n, dir;
  logic [7:0] a_ext, b_ext, a_in, b_in;
  bsd_pkg::bsd_pin_drive_type pins;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int seed, len;
  logic [35:0] sh, cap, cm;
  logic [10:0] ctl;
  logic [39:0] din, dout, exp_v, msk;
  logic [7:0] ops [$] = '{8'h0a, 8'h82, 8'h00, 8'h03, 8'h06, 8'h87,
    8'h09, 8'h8b, 8'h0c, 8'h8d, 8'h81, 8'h84, 8'h05, 8'h88, 8'h90,
    8'h8e, 8'h0f};

  // device drive wins on a pin whose enable is low
  assign a_in = (~pins.a_oe_n & pins.a_out) | (pins.a_oe_n & a_ext);
  assign b_in = (~pins.b_oe_n & pins.b_out) | (pins.b_oe_n & b_ext);

  bsd_boundary_regs uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .a_in(a_in), .b_in(b_in), .oe_n(oe_n), .dir(dir), .pins(pins));
  bsd_scan_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // hang guard, well above the ~17k cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // model: length and capture of the selected register, then update
  task automatic run_dr(input logic [7:0] op);
    din = 40'({$random(seed), $random(seed)});
    len = 36;
    cap = sh;
    cm = 36'hfffffffff;
    case (op)
      8'h0c: cap = ~sh;
      8'h82: begin
        cap = {4'ha, a_ext, 8'h00, a_ext, 8'h00};
        cm = 36'hfff00ff00;
      end
      8'h00, 8'h03: cm = 36'h0;
      8'h8e, 8'h0f: begin
        len = 11;
        cap = {25'h0, ctl};
      end
      8'h0a, 8'h8b: cap = sh;
      default: begin
        len = 1;
        cap = 36'h0;
      end
    endcase
    exp_v = (din << len) | 40'(cap & cm);
    msk = (40'hffffffffff << len) | 40'(cm);
    host.scan(1'b0, 40, din, dout);
    check(dout & msk, exp_v & msk);
    if (len == 36) begin
      sh = din[39:4];
    end
    if (len == 11) begin
      ctl = din[39:29];
    end
  endtask : run_dr

  initial begin
    seed = 99;
    sys_rst = 1'b1;
    oe_n = 1'b0;
    dir = 1'b1;
    a_ext = 8'h00;
    b_ext = 8'h00;
    sh = 36'h0;
    ctl = 11'h002;
    @(negedge clk_sys);
    a_ext = 8'($random(seed));
    b_ext = 8'($random(seed));
    // long enough for the test clock side to see it too
    repeat (12) @(negedge tck);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(posedge tck);
    host.tap_reset();
    run_dr(8'hff);
    foreach (ops[k]) begin
      host.scan(1'b1, 8, 40'(ops[k]), dout);
      check(dout[7:0], 8'h81);
      run_dr(ops[k]);
      case (ops[k])
        8'h82: check({pins.b_out, pins.b_oe_n, pins.a_oe_n}, {a_ext, 16'h00ff});
        8'h06: check({pins.a_oe_n, pins.b_oe_n}, 16'hffff);
        8'h87: check(pins, {sh[7:0], {8{~sh[34]}}, sh[23:16], {8{~sh[35]}}});
        default: ;
      endcase
      $display("op %h done", ops[k]);
    end
    summarize();
  end
endmodule : bsd_boundary_regs_tb
`default_nettype wire
